// [hw/analog_comparator_ctrl_consts.vh]
// offsets, field positions and reset values for the comparator control block
`ifndef ANALOG_COMPARATOR_CTRL_CONSTS_VH
`define ANALOG_COMPARATOR_CTRL_CONSTS_VH
// register indices as printed; byte address is four times the index
`define IDX_COMPARATOR_CONTROL_STATUS 8'h50
`define IDX_CONVERTER_CONTROL_B 8'h7b
`define IDX_COMPARATOR_PIN_INPUT_DISABLE 8'h7f
`define IDX_IRQ_STATUS 8'h80
`define IDX_IRQ_MASK 8'h81
`define IDX_SYSTEM_CONTROL 8'h82
`define ADDR_COMPARATOR_CONTROL_STATUS 12'h140
`define ADDR_CONVERTER_CONTROL_B 12'h1ec
`define ADDR_COMPARATOR_PIN_INPUT_DISABLE 12'h1fc
`define ADDR_IRQ_STATUS 12'h200
`define ADDR_IRQ_MASK 12'h204
`define ADDR_SYSTEM_CONTROL 12'h208
// control/status fields
`define BIT_POWER_OFF 7
`define BIT_BANDGAP_SELECT 6
`define BIT_RESULT 5
`define BIT_IRQ_FLAG 4
`define BIT_IRQ_ENABLE 3
`define BIT_CAPTURE_ROUTE 2
`define BIT_IRQ_MODE_HIGH 1
`define BIT_IRQ_MODE_LOW 0
// converter control b
`define BIT_NEG_MUX_ENABLE 6
`define CONV_B_TRIGGER_MASK 8'h07
// input disable
`define BIT_NEG_PIN_INPUT_DISABLE 1
`define BIT_POS_PIN_INPUT_DISABLE 0
// system control fields
`define BIT_CONVERTER_ENABLE 0
`define BIT_GLOBAL_IRQ_ENABLE 1
`define BIT_POWER_REDUCTION 2
`define SYSCTL_RESET 8'h04
// irq mode encodings
`define MODE_TOGGLE 2'h0
`define MODE_RESERVED 2'h1
`define MODE_FALLING 2'h2
`define MODE_RISING 2'h3
// status/mask event bits
`define EV_FLAG 0
`define EV_EDGE 1
`define REG_RESET 8'h00
`endif

// [hw/level_sync.v]
// two-flop synchroniser for one level
`timescale 1ns/1ps
module level_sync (
   input wire core_clk,
   input wire rstn,
   input wire din,
   output wire dout
);
   reg meta_q;
   reg sync_q;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end
   assign dout = sync_q;
endmodule

// [hw/analog_comparator_ctrl.v]
// comparator control and status logic with apb register slave
// Notes on behaviour
// (RL1) result one when positive exceeds negative
// (RL2) mux on, converter off: channel picks negative
// (RL3) otherwise dedicated negative pin is used
// (RL4) bandgap bit replaces positive pin input
// (RL5) result synchronised, one to two cycles
// (RL6) flag set on selected output event
// (RL7) modes: toggle, reserved, falling, rising
// (RL8) flag cleared by vector ack or write-one
// (RL9) request needs flag, enable, global enable
// (RL10) power-off bit writable any time
// (RL11) software disables irq before power change
// (RL12) software disables irq before mode change
// (RL13) capture route feeds timer capture input
// (RL14) software enables timer capture interrupt too
// (RL15) input disable forces pin reads zero
// (RL16) unused and reserved bits read zero
// (RL17) software clears power reduction before mux
// (RL18) edges from current versus previous sample
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "analog_comparator_ctrl_consts.vh"
module analog_comparator_ctrl (
   input wire core_clk,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   input wire compare_raw,
   input wire irq_vector_ack,
   input wire positive_comparator_pin,
   input wire negative_comparator_pin,
   output wire positive_select_bandgap,
   output wire negative_select_mux,
   output wire [2:0] negative_mux_channel,
   output wire comparator_power_off,
   output wire comparator_irq,
   output wire capture_route_enable,
   output wire capture_input,
   output wire pos_pin_digital_in,
   output wire neg_pin_digital_in,
   output wire pos_pin_buffer_off,
   output wire neg_pin_buffer_off,
   output wire irq
);
   // converter_channel_select comes from system control register bits 6:4 (chan_q)
   wire [2:0] converter_channel_select;
   reg [7:0] ctrl_q;
   reg [7:0] conv_b_q;
   reg [1:0] in_dis_q;
   reg [7:0] sysctl_q;
   reg [1:0] irq_status_q;
   reg [1:0] irq_mask_q;
   reg [2:0] chan_q;
   reg result_prev_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   wire comparator_result;
   wire wr_en;
   wire rd_en;
   wire rise;
   wire fall;
   reg event_hit;
   wire flag_clear;
   wire [1:0] irq_mode;

   localparam ST_IDLE = 2'b01;
   localparam ST_ACCESS = 2'b10;

   assign converter_channel_select = chan_q;

   // comparison itself is analog; the digital side gets its raw level
   level_sync u_result_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .din(compare_raw),
      .dout(comparator_result)
   ); // RL1 RL5

   // apb: every transfer is answered in its first access cycle
   always @* begin
      case (state_q)
         ST_IDLE: state_d = (psel && !penable) ? ST_ACCESS : ST_IDLE;
         ST_ACCESS: state_d = (psel && !penable) ? ST_ACCESS : ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   reg addr_ok;
   always @* begin
      case (paddr)
         `ADDR_COMPARATOR_CONTROL_STATUS: addr_ok = 1'b1;
         `ADDR_CONVERTER_CONTROL_B: addr_ok = 1'b1;
         `ADDR_COMPARATOR_PIN_INPUT_DISABLE: addr_ok = 1'b1;
         `ADDR_IRQ_STATUS: addr_ok = 1'b1;
         `ADDR_IRQ_MASK: addr_ok = 1'b1;
         `ADDR_SYSTEM_CONTROL: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;

   assign irq_mode = ctrl_q[`BIT_IRQ_MODE_HIGH:`BIT_IRQ_MODE_LOW];
   assign rise = comparator_result && !result_prev_q; // RL18
   assign fall = !comparator_result && result_prev_q; // RL18
   always @* begin
      case (irq_mode)
         `MODE_TOGGLE: event_hit = rise || fall; // RL7
         `MODE_FALLING: event_hit = fall; // RL7
         `MODE_RISING: event_hit = rise; // RL7
         default: event_hit = 1'b0; // reserved mode raises no flag; the edge status bit still sets on any edge
      endcase
   end
   assign flag_clear = irq_vector_ack ||
      (wr_en && paddr == `ADDR_COMPARATOR_CONTROL_STATUS && pwdata[`BIT_IRQ_FLAG]); // RL8

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= `REG_RESET;
         conv_b_q <= `REG_RESET;
         in_dis_q <= 2'b00;
         sysctl_q <= `SYSCTL_RESET;
         irq_mask_q <= 2'b00;
         chan_q <= 3'h0;
         result_prev_q <= 1'b0;
      end else begin
         result_prev_q <= comparator_result; // RL18
         // flag: a new event wins over a clear in the same cycle
         if (event_hit) begin
            ctrl_q[`BIT_IRQ_FLAG] <= 1'b1; // RL6
         end else if (flag_clear) begin
            ctrl_q[`BIT_IRQ_FLAG] <= 1'b0; // RL8
         end
         if (wr_en) begin
            case (paddr)
               `ADDR_COMPARATOR_CONTROL_STATUS: begin
                  // power-off takes effect whenever written
                  ctrl_q[`BIT_POWER_OFF] <= pwdata[`BIT_POWER_OFF]; // RL10
                  ctrl_q[`BIT_BANDGAP_SELECT] <= pwdata[`BIT_BANDGAP_SELECT]; // RL4
                  ctrl_q[`BIT_IRQ_ENABLE] <= pwdata[`BIT_IRQ_ENABLE];
                  ctrl_q[`BIT_CAPTURE_ROUTE] <= pwdata[`BIT_CAPTURE_ROUTE]; // RL13
                  ctrl_q[`BIT_IRQ_MODE_HIGH] <= pwdata[`BIT_IRQ_MODE_HIGH];
                  ctrl_q[`BIT_IRQ_MODE_LOW] <= pwdata[`BIT_IRQ_MODE_LOW];
               end
               `ADDR_CONVERTER_CONTROL_B: begin
                  conv_b_q <= pwdata[7:0] & (8'h40 | `CONV_B_TRIGGER_MASK); // RL16
               end
               `ADDR_COMPARATOR_PIN_INPUT_DISABLE: begin
                  in_dis_q <= pwdata[1:0]; // RL16
               end
               `ADDR_IRQ_MASK: begin
                  irq_mask_q <= pwdata[1:0];
               end
               `ADDR_SYSTEM_CONTROL: begin
                  sysctl_q <= {5'h00, pwdata[2:0]};
                  chan_q <= pwdata[6:4];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // sticky interrupt status, write-one-to-clear, set wins
   wire [1:0] ev_set;
   wire [1:0] ev_clr;
   assign ev_set = {rise || fall, event_hit};
   assign ev_clr = (wr_en && paddr == `ADDR_IRQ_STATUS) ? pwdata[1:0] : 2'b00;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_status_q <= 2'b00;
      end else begin
         irq_status_q <= ev_set | (irq_status_q & ~ev_clr);
      end
   end
   assign irq = |(irq_status_q & irq_mask_q);

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `ADDR_COMPARATOR_CONTROL_STATUS: prdata <= {24'h000000, ctrl_q[7:6],
               comparator_result, ctrl_q[4:0]}; // RL5
            `ADDR_CONVERTER_CONTROL_B: prdata <= {24'h000000, conv_b_q}; // RL16
            `ADDR_COMPARATOR_PIN_INPUT_DISABLE: prdata <= {30'h0, in_dis_q}; // RL16
            `ADDR_IRQ_STATUS: prdata <= {30'h0, irq_status_q};
            `ADDR_IRQ_MASK: prdata <= {30'h0, irq_mask_q};
            `ADDR_SYSTEM_CONTROL: prdata <= {25'h0, chan_q, 1'b0, sysctl_q[2:0]};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   assign positive_select_bandgap = ctrl_q[`BIT_BANDGAP_SELECT]; // RL4
   assign negative_select_mux = conv_b_q[`BIT_NEG_MUX_ENABLE] &&
      !sysctl_q[`BIT_CONVERTER_ENABLE]; // RL2 RL3
   assign negative_mux_channel = converter_channel_select; // RL2
   assign comparator_power_off = ctrl_q[`BIT_POWER_OFF]; // RL10
   assign comparator_irq = ctrl_q[`BIT_IRQ_FLAG] && ctrl_q[`BIT_IRQ_ENABLE] &&
      sysctl_q[`BIT_GLOBAL_IRQ_ENABLE]; // RL9
   assign capture_route_enable = ctrl_q[`BIT_CAPTURE_ROUTE]; // RL13
   assign capture_input = ctrl_q[`BIT_CAPTURE_ROUTE] & comparator_result; // RL13
   assign pos_pin_buffer_off = in_dis_q[`BIT_POS_PIN_INPUT_DISABLE]; // RL15
   assign neg_pin_buffer_off = in_dis_q[`BIT_NEG_PIN_INPUT_DISABLE]; // RL15
   assign pos_pin_digital_in = positive_comparator_pin & ~in_dis_q[0]; // RL15
   assign neg_pin_digital_in = negative_comparator_pin & ~in_dis_q[1]; // RL15
endmodule

// [verification/analog_comparator_ctrl_properties.sv]
// port-level checks on the comparator control block
`timescale 1ns/1ps
module analog_comparator_ctrl_properties (
   input logic core_clk,
   input logic rstn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic compare_raw,
   input logic irq_vector_ack,
   input logic positive_comparator_pin,
   input logic negative_comparator_pin,
   input logic positive_select_bandgap,
   input logic negative_select_mux,
   input logic [2:0] negative_mux_channel,
   input logic comparator_power_off,
   input logic comparator_irq,
   input logic capture_route_enable,
   input logic capture_input,
   input logic pos_pin_digital_in,
   input logic neg_pin_digital_in,
   input logic pos_pin_buffer_off,
   input logic neg_pin_buffer_off,
   input logic irq
);
   logic [4:0] hist_q;
   // any raw movement in this window may legally raise a flag
   wire moved = |{hist_q, compare_raw} && !(&{hist_q, compare_raw});
   wire wr = psel && penable && pwrite;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) hist_q <= 5'h00;
      else hist_q <= {hist_q[3:0], compare_raw};
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sync_capture_a: assert property (capture_route_enable |->
      capture_input == $past(compare_raw) || capture_input == $past(compare_raw, 2))
      else $error("capture input is not the synced result");
   capture_off_a: assert property (!capture_route_enable |-> !capture_input)
      else $error("capture input driven with route off");
   pos_digital_a: assert property (pos_pin_digital_in ==
      (positive_comparator_pin && !pos_pin_buffer_off)) else $error("positive pin input wrong");
   neg_digital_a: assert property (neg_pin_digital_in ==
      (negative_comparator_pin && !neg_pin_buffer_off)) else $error("negative pin input wrong");
   flag_ack_a: assert property (irq_vector_ack && !moved |=> !comparator_irq)
      else $error("vector ack left the flag set");
   irq_cause_a: assert property ($rose(comparator_irq) |-> moved || $past(wr))
      else $error("comparator irq rose without cause");
   irq_line_a: assert property ($rose(irq) |-> moved || $past(wr))
      else $error("irq rose without cause");
   regs_hold_a: assert property (!$past(wr) |-> $stable({positive_select_bandgap,
      negative_select_mux, negative_mux_channel, comparator_power_off, capture_route_enable}))
      else $error("control output moved without a write");
endmodule

// [verification/analog_far_side.sv]
// behavioural analog side: pin voltages and the comparator itself
`timescale 1ns/1ps
module analog_far_side (
   input wire logic positive_select_bandgap,
   input wire logic negative_select_mux,
   input wire logic [2:0] negative_mux_channel,
   input wire logic comparator_power_off,
   input int ain_pos,
   input int ain_neg,
   output logic compare_raw,
   output logic positive_comparator_pin,
   output logic negative_comparator_pin
);
   localparam int bandgap_mv = 550;
   int vp;
   int vn;
   always_comb begin
      vp = positive_select_bandgap ? bandgap_mv : ain_pos;
      vn = negative_select_mux ? 100 * negative_mux_channel : ain_neg;
      compare_raw = !comparator_power_off && vp > vn;
      positive_comparator_pin = ain_pos > 800;
      negative_comparator_pin = ain_neg > 800;
   end
endmodule

// [verification/tb.sv]
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "analog_comparator_ctrl_consts.vh"
module tb;
   localparam logic [11:0] ctl = `ADDR_COMPARATOR_CONTROL_STATUS, cvb = `ADDR_CONVERTER_CONTROL_B;
   localparam logic [11:0] dis = `ADDR_COMPARATOR_PIN_INPUT_DISABLE, sys = `ADDR_SYSTEM_CONTROL;
   localparam logic [11:0] sts = `ADDR_IRQ_STATUS, msk = `ADDR_IRQ_MASK;
   logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, irq_vector_ack = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   int ain_pos = 0, ain_neg = 900, mismatches = 0, total_checks = 0;
   wire pready, pslverr, compare_raw, positive_comparator_pin, negative_comparator_pin;
   wire positive_select_bandgap, negative_select_mux, comparator_power_off, comparator_irq;
   wire capture_route_enable, capture_input, pos_pin_digital_in, neg_pin_digital_in, irq;
   wire pos_pin_buffer_off, neg_pin_buffer_off;
   wire [2:0] negative_mux_channel;
   wire [31:0] prdata;
   analog_comparator_ctrl u_analog_comparator_ctrl (.core_clk, .rstn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .compare_raw, .irq_vector_ack,
      .positive_comparator_pin, .negative_comparator_pin, .positive_select_bandgap,
      .negative_select_mux, .negative_mux_channel, .comparator_power_off, .comparator_irq,
      .capture_route_enable, .capture_input, .pos_pin_digital_in, .neg_pin_digital_in,
      .pos_pin_buffer_off, .neg_pin_buffer_off, .irq);
   analog_far_side u_analog_far_side (.positive_select_bandgap, .negative_select_mux,
      .negative_mux_channel, .comparator_power_off, .ain_pos, .ain_neg, .compare_raw,
      .positive_comparator_pin, .negative_comparator_pin);
   initial forever #12.5 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1 && ++n < 40);
      if (n == 40) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      #1;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd & m, e);
   endtask
   // raw settles through sync and flag logic within four edges
   task automatic raw(input int v);
      @(posedge core_clk);
      ain_pos <= v;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task automatic t_regs;
      rdc(ctl, 32'hff, 0);
      apb(1, dis, 32'hff);
      rdc(dis, 32'hff, 32'h03);
      chk({pos_pin_buffer_off, neg_pin_buffer_off, neg_pin_digital_in}, 3'h6);
      apb(1, dis, 0);
      chk(neg_pin_digital_in, 1);
      apb(1, cvb, 32'hff);
      rdc(cvb, 32'hff, 32'h47);
      apb(1, ctl, 32'h80);
      chk(comparator_power_off, 1);
      apb(1, ctl, 0);
      apb(0, 12'hffc, 0);
      chk({err, rd[7:0]}, 9'h100);
   endtask
   task automatic t_mux;
      raw(350);
      for (int i = 0; i < 8; i++) begin
         apb(1, sys, i << 4);
         chk({negative_select_mux, negative_mux_channel}, 8 + i);
         repeat (3) @(posedge core_clk);
         rdc(ctl, 32'h20, (i < 4) ? 32'h20 : 0);
      end
      apb(1, sys, 32'h01);
      chk(negative_select_mux, 0);
      apb(1, ctl, 32'h40);
      @(posedge core_clk);
      ain_neg <= 500;
      repeat (3) @(posedge core_clk);
      rdc(ctl, 32'h20, 32'h20);
   endtask
   task automatic t_modes;
      @(posedge core_clk);
      ain_neg <= 900;
      apb(1, ctl, 0);
      raw(0);
      for (int m = 0; m < 4; m++) begin
         apb(1, ctl, 32'h10 | m);
         raw(2000);
         rdc(ctl, 32'h10, (m == 0 || m == 3) ? 32'h10 : 0);
         apb(1, ctl, 32'h10 | m);
         raw(0);
         rdc(ctl, 32'h10, (m == 0 || m == 2) ? 32'h10 : 0);
      end
      apb(1, ctl, 32'h10);
      apb(1, sys, 32'h03);
      apb(1, ctl, 32'h08);
      raw(2000);
      chk(comparator_irq, 1);
      apb(1, sys, 32'h01);
      chk(comparator_irq, 0);
      apb(1, sys, 32'h03);
      @(posedge core_clk);
      irq_vector_ack <= 1;
      @(posedge core_clk);
      irq_vector_ack <= 0;
      #1;
      chk(comparator_irq, 0);
      apb(1, ctl, 0);
   endtask
   task automatic t_irq;
      apb(1, msk, 0);
      apb(1, sts, 32'h03);
      apb(1, ctl, 32'h04);
      raw(0);
      chk({irq, capture_input}, 0);
      rdc(sts, 32'hff, 32'h03);
      apb(1, msk, 32'h02);
      chk(irq, 1);
      apb(1, sts, 32'h02);
      rdc(sts, 32'hff, 32'h01);
      chk(irq, 0);
      raw(2000);
      chk(capture_input, 1);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rstn <= 1;
      t_regs;
      t_mux;
      t_modes;
      t_irq;
      end_of_test;
   end
   initial begin
      #100us;
      mismatches++;
      end_of_test;
   end
endmodule
bind analog_comparator_ctrl analog_comparator_ctrl_properties u_analog_comparator_ctrl_properties (
   .core_clk, .rstn, .psel, .penable, .pwrite, .compare_raw, .irq_vector_ack,
   .positive_comparator_pin, .negative_comparator_pin, .positive_select_bandgap,
   .negative_select_mux, .negative_mux_channel, .comparator_power_off, .comparator_irq,
   .capture_route_enable, .capture_input, .pos_pin_digital_in, .neg_pin_digital_in,
   .pos_pin_buffer_off, .neg_pin_buffer_off, .irq);
